// ### logic/irrxd_decoder.sv
// Infrared receive decoder: pulse demodulator feeding the UART receiver.
`timescale 1ns/1ps
`default_nettype none

module irrxd_decoder (
    input  wire logic mclk,               // System clock, 250 MHz.
    input  wire logic rst_n,              // Synchronous reset, active low.
    input  wire logic baudTick,           // One-cycle pulse per baud clock period.
    input  wire logic infraredCodecEnable,// Codec enable level.
    input  wire logic infraredReceiveLine,// Receive pin, raw infrared or plain UART data.
    input  wire logic bitReady,           // Downstream accepts a decoded bit.
    output logic      uartRxd,            // Serial input to the UART receiver.
    output logic      bitValid,           // A decoded bit waits in the buffer.
    output logic      bitData,            // Value of that bit.
    output logic      decodeReady         // Buffer can take another bit.
);
    // ==========================================================
    // Input synchroniser and edge detector.
    logic sync1_r, sync2_r, prev_r;
    logic fallEdge;

    // The pin is asynchronous to mclk, so it crosses through two flops first.
    // The edge detector and the bypass path read only the second flop; reading the
    // first one anywhere would let a metastable level leak into the decoder.
    // Reset loads the idle (high) level so no false falling edge follows reset.
    // Two flops against metastability; edge taken from the second one only.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
        end else begin
            sync1_r <= infraredReceiveLine;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign fallEdge = prev_r & ~sync2_r;

    // ==========================================================
    // Baud counter and window state machine.
    logic [irrxd_pkg::CNT_W-1:0] cnt_r;
    irrxd_pkg::irrxd_state_type  state_r;
    logic                        pending_r;  // Pulse seen, waiting for count 8.
    logic                        decoded_r;
    logic                        emit;
    logic                        emitVal;

    // Count decoding shared by the emitter and the window state machine.
    // True when the local counter stands at the update point of a bit.
    function automatic logic atUpdate(input logic [irrxd_pkg::CNT_W-1:0] cnt);
        atUpdate = (cnt == irrxd_pkg::CNT_UPDATE);
    endfunction

    // True on the last count before the sampling window opens.
    function automatic logic atWindowEdge(input logic [irrxd_pkg::CNT_W-1:0] cnt);
        atWindowEdge = (cnt == (irrxd_pkg::CNT_WIN_OPEN - 4'h1));
    endfunction

    // The emitter is the only place the decoded level is born; the window state
    // machine only decides whether a pulse was seen, never when the UART sees it.

    // Emit fires at count 8 in either window phase: eight periods after the pulse in FIRST, twenty-four in SECOND.
    assign emit    = baudTick && (state_r != irrxd_pkg::IRRXD_IDLE)
                     && atUpdate(cnt_r) && !fallEdge;
    assign emitVal = ~pending_r;

    // Counter wraps at 15 so a bit lasts sixteen baud periods.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r <= irrxd_pkg::CNT_ZERO;
        end else if (fallEdge && infraredCodecEnable) begin
            cnt_r <= irrxd_pkg::CNT_ZERO;
        end else if (baudTick) begin
            cnt_r <= (cnt_r == irrxd_pkg::CNT_LAST) ? irrxd_pkg::CNT_ZERO
                                                    : cnt_r + 4'h1;
        end
    end

    // FIRST: from pulse until the window opens at 12; SECOND: window open until 8.
    always_ff @(posedge mclk) begin
        if (!rst_n || !infraredCodecEnable) begin
            state_r   <= irrxd_pkg::IRRXD_IDLE;
            pending_r <= 1'b0;
        end else if (fallEdge && (state_r != irrxd_pkg::IRRXD_FIRST)) begin
            // A pulse in idle or inside the window restarts the cycle.
            state_r   <= irrxd_pkg::IRRXD_FIRST;
            pending_r <= 1'b1;
        end else if (baudTick) begin
            unique case (state_r)
                irrxd_pkg::IRRXD_IDLE: begin
                    pending_r <= 1'b0;
                end
                irrxd_pkg::IRRXD_FIRST: begin
                    if (atUpdate(cnt_r)) begin
                        pending_r <= 1'b0;
                    end
                    if (atWindowEdge(cnt_r)) begin
                        state_r <= irrxd_pkg::IRRXD_SECOND;
                    end
                end
                irrxd_pkg::IRRXD_SECOND: begin
                    // No pulse by count 8: bit is one, return to idle.
                    if (atUpdate(cnt_r)) begin
                        state_r <= irrxd_pkg::IRRXD_IDLE;
                    end
                end
                default: begin
                    state_r <= irrxd_pkg::IRRXD_IDLE;
                end
            endcase
        end
    end

    // Decoded level changes only on emit, reset or disable (both force one), so counter resync never moves UART edges.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            decoded_r <= 1'b1;
        end else if (!infraredCodecEnable) begin
            decoded_r <= 1'b1;
        end else if (emit) begin
            decoded_r <= emitVal;
        end
    end

    // The bypass path uses the synchronised pin, so it lags the pin by three
    // clocks; a UART sampling at sixteen baud periods per bit never notices that.
    // UART input: decoder when enabled, else the pin passes straight through.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            uartRxd <= 1'b1;
        end else begin
            uartRxd <= infraredCodecEnable ? decoded_r : sync2_r;
        end
    end

    // ==========================================================
    // Two-entry buffer of decoded bits; a receiver stall loses nothing until both entries are full.
    // The handshake is taken at the ports: a bit leaves only when bitValid and
    // bitReady are both high at a rising edge, so no bit goes unseen.
    irrxd_pkg::irrxd_bit_type buf_r   [irrxd_pkg::BUF_DEPTH];
    irrxd_pkg::irrxd_bit_type buf_nxt [irrxd_pkg::BUF_DEPTH];
    logic                     push;
    logic                     pop;

    // Port outputs mirror the buffer exactly, so the handshake can use them.
    assign pop  = bitValid && bitReady;
    // A bit that finds both entries full and no pop is dropped; uartRxd still shows it.
    assign push = emit && (decodeReady || pop);

    // Next contents; entry 0 is the head, entry 1 shifts down when the head leaves.
    // A leaving head keeps its data bit, so bitData stands after the last pop.
    always_comb begin
        buf_nxt[0] = buf_r[0];
        buf_nxt[1] = buf_r[1];
        if (pop) begin
            if (buf_r[1].valid) begin
                buf_nxt[0]       = buf_r[1];
                buf_nxt[1].valid = 1'b0;
            end else begin
                buf_nxt[0].valid = 1'b0;
            end
        end
        if (push) begin
            if (buf_nxt[0].valid) begin
                buf_nxt[1] = '{valid: 1'b1, data: emitVal};
            end else begin
                buf_nxt[0] = '{valid: 1'b1, data: emitVal};
            end
        end
    end

    // Buffer storage; reset leaves both entries empty at the line's high level.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            buf_r[0] <= '{valid: 1'b0, data: 1'b1};
            buf_r[1] <= '{valid: 1'b0, data: 1'b1};
        end else begin
            buf_r[0] <= buf_nxt[0];
            buf_r[1] <= buf_nxt[1];
        end
    end

    // Port copies loaded from the same next value, so they never lag the buffer.
    // Keeping them as separate flops keeps every output straight from a register.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bitValid    <= 1'b0;
            bitData     <= 1'b1;
            decodeReady <= 1'b1;
        end else begin
            bitValid    <= buf_nxt[0].valid;
            bitData     <= buf_nxt[0].data;
            decodeReady <= !buf_nxt[1].valid;
        end
    end
endmodule

`default_nettype wire

// ### logic/irrxd_pkg.sv
// Package of constants and types for the infrared receive decoder.
package irrxd_pkg;
    // ==========================================================
    // Baud counter figures.
    localparam int          CNT_W        = 4;
    localparam logic [3:0]  CNT_LAST     = 4'hF;  // Counter runs 0 to 15.
    localparam logic [3:0]  CNT_ZERO     = 4'h0;
    localparam logic [3:0]  CNT_UPDATE   = 4'h8;  // Output updated at count 8.
    localparam logic [3:0]  CNT_WIN_OPEN = 4'hC;  // Window opens at count 12.
    localparam int          BUF_DEPTH    = 2;

    // ==========================================================
    // Decoder states.
    typedef enum logic [1:0] {
        IRRXD_IDLE,
        IRRXD_FIRST,
        IRRXD_SECOND
    } irrxd_state_type;

    // One decoded bit with its handshake.
    typedef struct packed {
        logic valid;
        logic data;
    } irrxd_bit_type;
endpackage

// ### verification/irrxd_decoder_assertions.sv
// Port checker for the infrared receive decoder.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker.
module irrxd_decoder_assertions (
    input wire logic mclk,                // Clock.
    input wire logic rst_n,               // Reset, active low.
    input wire logic baudTick,            // Baud pulse.
    input wire logic infraredCodecEnable, // Enable.
    input wire logic infraredReceiveLine, // Pin.
    input wire logic bitReady,            // Pop.
    input wire logic uartRxd,             // UART input.
    input wire logic bitValid,            // Head valid.
    input wire logic bitData,             // Head data.
    input wire logic decodeReady          // Not full.
);
    logic [4:0] hiCnt_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Baud periods of quiet line; saturates so a long idle never wraps.
    always_ff @(posedge mclk) begin
        if (!rst_n || !infraredReceiveLine) begin
            hiCnt_r <= 5'h00;
        end else if (baudTick && hiCnt_r != 5'h1F) begin
            hiCnt_r <= hiCnt_r + 5'h01;
        end
    end
    a_reset_vals:
    assert property ($rose(rst_n) |-> uartRxd && bitData && !bitValid && decodeReady)
        else $error("outputs not at reset values");
    a_tick_timed:
    assert property ($past(rst_n) && infraredCodecEnable && $past(infraredCodecEnable, 2)
        && $changed(uartRxd) |->
        $past(baudTick) || $past(baudTick, 2) || $past(baudTick, 3))
        else $error("output moved without a baud period");
    a_idle_one:
    assert property (hiCnt_r >= 5'h18 |-> uartRxd) else $error("idle line not decoded as one");
    a_lag_early:
    assert property (infraredCodecEnable && $fell(infraredReceiveLine) && uartRxd
        |=> uartRxd[*8])
        else $error("output followed pulse too early");
    a_lag_zero:
    assert property (infraredCodecEnable && $fell(infraredReceiveLine) |->
        ##[28:44] !uartRxd)
        else $error("pulse not decoded as zero");
    a_valid_hold:
    assert property (bitValid && !bitReady && !$past(bitReady) |=> bitValid && $stable(bitData))
        else $error("stalled bit lost");
    a_data_match:
    assert property ($rose(bitValid) |-> ##[0:2] (uartRxd == bitData))
        else $error("buffered bit differs from output");
    a_ready_empty:
    assert property (!bitValid |-> decodeReady) else $error("empty buffer not ready");
endmodule
bind irrxd_decoder irrxd_decoder_assertions u_chk (.mclk(mclk), .rst_n(rst_n),
    .baudTick(baudTick), .infraredCodecEnable(infraredCodecEnable),
    .infraredReceiveLine(infraredReceiveLine), .bitReady(bitReady), .uartRxd(uartRxd),
    .bitValid(bitValid), .bitData(bitData), .decodeReady(decodeReady));
`default_nettype wire

// ### verification/irrxd_ir_xcvr.sv
// Model of the infrared transceiver that drives the receive pin.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Transceiver.
module irrxd_ir_xcvr (
    input  wire logic       mclk,     // Clock.
    input  wire logic       baudTick, // Baud pulse.
    input  wire logic       go,       // Start a frame.
    input  wire logic [7:0] bits,     // Frame, bit 0 first.
    output logic            line,     // Pin, idle high.
    output logic            busy      // Frame in flight.
);
    logic [7:0] sh_r;
    logic [7:0] tk_r;
    initial begin
        busy = 1'b0;
        line = 1'b1;
    end
    // Zero bits pulse low for 3 of 16 baud periods; a one leaves the line high.
    always @(posedge mclk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            sh_r <= bits;
            tk_r <= 8'h00;
        end else if (busy && baudTick) begin
            tk_r <= tk_r + 8'h01;
            busy <= (tk_r != 8'h7F);
            if (tk_r[3:0] == 4'hF) begin
                sh_r <= sh_r >> 1;
            end
        end
        line <= !(busy && tk_r[3:0] < 4'h3 && !sh_r[0]);
    end
endmodule
`default_nettype wire

// ### verification/test_infrared_receive_decoder.sv
// Testbench for the infrared receive decoder.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench.
module test_infrared_receive_decoder;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic baudTick = 1'b0;
    logic bitReady = 1'b1;
    logic go = 1'b0;
    logic enable = 1'b1;
    logic [7:0] bits = 8'h00;
    logic [1:0] div = 2'h0;
    wire logic line, busy, uartRxd, bitValid, bitData, decodeReady;
    int n_errors = 0;
    int check_count = 0;
    // 250 MHz, far above the slowest clock that still sees short pulses.
    always #2 mclk = ~mclk;
    // One baud period every four clocks keeps frames short.
    always @(posedge mclk) begin
        div <= div + 2'h1;
        baudTick <= (div == 2'h3);
    end
    // Codec is enabled before any traffic reaches the pin.
    irrxd_decoder dut (.mclk(mclk), .rst_n(rst_n), .baudTick(baudTick),
        .infraredCodecEnable(enable), .infraredReceiveLine(line), .bitReady(bitReady),
        .uartRxd(uartRxd), .bitValid(bitValid), .bitData(bitData),
        .decodeReady(decodeReady));
    irrxd_ir_xcvr xcvr (.mclk(mclk), .baudTick(baudTick), .go(go), .bits(bits),
        .line(line), .busy(busy));
    task chk(input string nm, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", nm, e, s);
        end
    endtask
    task ticks(input int n);
        repeat (n) begin
            do @(posedge mclk); while (!baudTick);
        end
    endtask
    task frame(input logic [7:0] b);
        while (busy) @(posedge mclk);
        @(posedge mclk);
        bits <= b;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask
    task t_stream();
        frame(8'hA6);
        for (int k = 0; k < 8; k++) begin
            ticks(k == 0 ? 12 : 16);
            chk("uartRxd", bits[k], uartRxd);
        end
    endtask
    task t_full();
        bitReady <= 1'b0;
        frame(8'hF8);
        ticks(140);
        chk("decodeReady", 1'b0, decodeReady);
        chk("bitValid", 1'b1, bitValid);
        chk("bitData", 1'b0, bitData);
        bitReady <= 1'b1;
        ticks(4);
        chk("bitValid", 1'b0, bitValid);
        chk("decodeReady", 1'b1, decodeReady);
    endtask
    task t_reset();
        frame(8'h00);
        ticks(40);
        rst_n <= 1'b0;
        ticks(1);
        chk("uartRxd", 1'b1, uartRxd);
        chk("bitValid", 1'b0, bitValid);
        rst_n <= 1'b1;
        ticks(140);
        chk("uartRxd", 1'b1, uartRxd);
    endtask
    task t_bypass();
        enable <= 1'b0;
        ticks(2);
        frame(8'h00);
        ticks(2);
        chk("uartRxd", 1'b0, uartRxd);
        ticks(8);
        chk("uartRxd", 1'b1, uartRxd);
        while (busy) @(posedge mclk);
        ticks(30);
        enable <= 1'b1;
    endtask
    task results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence; the decoder waits out reset before any frame.
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        ticks(4);
        t_stream();
        t_full();
        t_reset();
        t_bypass();
        results();
    end
    // Watchdog sized well past the four frames.
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        results();
    end
endmodule
`default_nettype wire
